// [wpr_defines.svh]
// Constants for the wormhole packet router: widths, depths and field layout
`ifndef WPR_DEFINES_SVH
`define WPR_DEFINES_SVH

`define WPR_NPORTS     4
`define WPR_PORT_W     2
`define WPR_DATA_W     8
`define WPR_CHAR_W     10
`define WPR_FIFO_DEPTH 4
`define WPR_FIFO_PTR_W 2
`define WPR_FIFO_CNT_W 3

`endif

// [wpr_pkg.sv]
// Types shared by the wormhole packet router files
`include "wpr_defines.svh"

package wpr_pkg;

  // One link character: data, or an end marker when is_ctrl is set
  typedef struct packed {
    logic                    is_ctrl;  // 1: end-of-packet marker
    logic                    err;      // With is_ctrl: error end marker
    logic [`WPR_DATA_W-1:0]  data;     // Data character value
  } wpr_char_t;

  // Per-input packet state
  typedef enum logic {
    WPR_WAIT_HDR,
    WPR_FORWARD
  } wpr_state_t;

endpackage

// [wpr_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "wpr_defines.svh"

module wpr_fifo #(
  parameter int WIDTH = `WPR_CHAR_W,
  parameter int DEPTH = `WPR_FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic [WIDTH-1:0]      rd_data_out
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CW-1:0]    count_q, count_d;
  logic             ready_q, ready_d;
  logic             push, pop;

  // Handshakes; ready is a flop, so a push is only taken with space left
  assign push         = wr_valid_in && ready_q;
  assign pop          = rd_ready_in && (count_q != '0);
  assign wr_ready_out = ready_q;
  assign rd_valid_out = (count_q != '0);
  assign rd_data_out  = mem_q[rd_ptr_q];

  // Next pointers, count and storage
  always_comb begin
    mem_d    = mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d  = count_q;
    if (push) begin
      mem_d[wr_ptr_q] = wr_data_in;
      wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
    // Withholding ready is the flow-control credit toward the sender
    ready_d = (count_d < CW'(DEPTH));
  end

  // Registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b1;
    end else begin
      mem_q    <= mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      ready_q  <= ready_d;
    end
  end

  // A full buffer refuses data
  full_no_credit_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (count_q == CW'(DEPTH)) |-> !wr_ready_out)
    else $error("FIFO full but still ready");

  // A refused write leaves the buffer untouched
  refused_write_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_valid_in && !wr_ready_out && !rd_ready_in) |=> $stable(count_q))
    else $error("Write taken while not ready");

endmodule // wpr_fifo

// [wpr_router.sv]
// Wormhole packet router: per-input buffers, port allocation, forwarding
`timescale 1ns/1ps
`include "wpr_defines.svh"

module wpr_router (
  input  wire logic                       CORE_CLK_IN,
  input  wire logic                       RESET_N_IN,
  input  wire logic [`WPR_NPORTS-1:0]     IN_VALID_IN,
  input  wpr_pkg::wpr_char_t              IN_CHAR_IN [`WPR_NPORTS],
  output logic [`WPR_NPORTS-1:0]          IN_READY_OUT,
  output logic [`WPR_NPORTS-1:0]          OUT_VALID_OUT,
  output wpr_pkg::wpr_char_t              OUT_CHAR_OUT [`WPR_NPORTS],
  input  wire logic [`WPR_NPORTS-1:0]     OUT_READY_IN,
  input  wire logic [`WPR_NPORTS-1:0]     HDR_DELETE_IN,
  output logic [`WPR_NPORTS-1:0]          PORT_BUSY_OUT
);

  import wpr_pkg::*;

  localparam int NP = `WPR_NPORTS;
  localparam int PW = `WPR_PORT_W;

  // Per-input buffer heads
  logic [NP-1:0]       head_valid;
  wpr_char_t           head_char [NP];
  logic [NP-1:0]       pop;
  logic [NP-1:0]       grant;
  logic [PW-1:0]       req_port [NP];

  // Per-input packet state
  wpr_state_t          state_q [NP];
  wpr_state_t          state_d [NP];
  logic [PW-1:0]       tgt_q [NP];
  logic [PW-1:0]       tgt_d [NP];

  // Per-output allocation and output register
  logic [NP-1:0]       busy_q, busy_d;
  logic [PW-1:0]       owner_q [NP];
  logic [PW-1:0]       owner_d [NP];
  logic [NP-1:0]       out_valid_q, out_valid_d;
  wpr_char_t           out_char_q [NP];
  wpr_char_t           out_char_d [NP];
  logic [NP-1:0]       load_end;

  // One buffer per input; its ready is the link credit
  // Four deep covers the grant delay without holding whole packets
  for (genvar i = 0; i < NP; i++) begin : g_in
    wpr_fifo #(
      .WIDTH (`WPR_CHAR_W),
      .DEPTH (`WPR_FIFO_DEPTH)
    ) u_fifo (
      .clk_in       (CORE_CLK_IN),
      .rst_n_in     (RESET_N_IN),
      .wr_valid_in  (IN_VALID_IN[i]),
      .wr_ready_out (IN_READY_OUT[i]),
      .wr_data_in   (IN_CHAR_IN[i]),
      .rd_valid_out (head_valid[i]),
      .rd_ready_in  (pop[i]),
      .rd_data_out  (head_char[i])
    );
    // Leading identifier decoded straight from the buffer head
    assign req_port[i] = head_char[i].data[PW-1:0];
  end

  // Allocation: lowest input index wins a free output
  // Fixed priority is cheap, but a busy low input can starve higher ones
  always_comb begin
    logic taken;
    taken = 1'b0;
    grant = '0;
    for (int o = 0; o < NP; o++) begin
      taken = 1'b0;
      for (int i = 0; i < NP; i++) begin
        if (!taken && !busy_q[o] && state_q[i] == WPR_WAIT_HDR &&
            head_valid[i] && !head_char[i].is_ctrl &&
            req_port[i] == PW'(o)) begin
          taken    = 1'b1;
          grant[i] = 1'b1;
        end
      end
    end
  end

  // Next state of inputs, allocation and output registers
  always_comb begin
    logic [PW-1:0] o;
    o           = '0;
    state_d     = state_q;
    tgt_d       = tgt_q;
    busy_d      = busy_q;
    owner_d     = owner_q;
    out_valid_d = out_valid_q;
    out_char_d  = out_char_q;
    pop         = '0;
    load_end    = '0;
    // Taken output characters leave the register
    for (int k = 0; k < NP; k++) begin
      if (OUT_READY_IN[k]) begin
        out_valid_d[k] = 1'b0;
      end
    end
    for (int i = 0; i < NP; i++) begin
      unique case (state_q[i])
        WPR_WAIT_HDR: begin
          o = req_port[i];
          if (head_valid[i] && head_char[i].is_ctrl) begin
            // Stray marker with no header: drop, keep waiting
            pop[i] = 1'b1;
          end else if (grant[i]) begin
            busy_d[o]  = 1'b1;
            owner_d[o] = PW'(i);
            tgt_d[i]   = o;
            state_d[i] = WPR_FORWARD;
            // Deleted identifier is consumed, next character leads
            pop[i] = HDR_DELETE_IN[o];
          end
        end
        WPR_FORWARD: begin
          o = tgt_q[i];
          // Whole packet through one output, one char per cycle
          if (head_valid[i] && (!out_valid_q[o] || OUT_READY_IN[o])) begin
            pop[i]         = 1'b1;
            out_valid_d[o] = 1'b1;
            out_char_d[o]  = head_char[i];
            if (head_char[i].is_ctrl) begin
              // EOP and EEP both tear the connection down
              busy_d[o]   = 1'b0;
              load_end[o] = 1'b1;
              state_d[i]  = WPR_WAIT_HDR;
            end
          end
        end
      endcase
    end
  end

  // Registers; reset leaves all outputs free
  // A packet cut by reset is lost; its sender has to send it again
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int k = 0; k < NP; k++) begin
        state_q[k]    <= WPR_WAIT_HDR;
        tgt_q[k]      <= '0;
        owner_q[k]    <= '0;
        out_char_q[k] <= '0;
      end
      busy_q      <= '0;
      out_valid_q <= '0;
    end else begin
      state_q     <= state_d;
      tgt_q       <= tgt_d;
      busy_q      <= busy_d;
      owner_q     <= owner_d;
      out_valid_q <= out_valid_d;
      out_char_q  <= out_char_d;
    end
  end

  // Outputs straight from registers
  assign OUT_VALID_OUT = out_valid_q;
  assign OUT_CHAR_OUT  = out_char_q;
  assign PORT_BUSY_OUT = busy_q;

  // Outputs asked for by a waiting header, busy or not
  logic [NP-1:0]       hdr_wants;
  always_comb begin
    hdr_wants = '0;
    for (int i = 0; i < NP; i++) begin
      if (state_q[i] == WPR_WAIT_HDR && head_valid[i] &&
          !head_char[i].is_ctrl) begin
        hdr_wants[req_port[i]] = 1'b1;
      end
    end
  end

  // Checks per input
  for (genvar i = 0; i < NP; i++) begin : g_chk_in
    sequence s_claim;
      grant[i] && !busy_q[req_port[i]];
    endsequence
    sequence s_connected;
      state_q[i] == WPR_FORWARD && busy_q[tgt_q[i]] &&
      owner_q[tgt_q[i]] == PW'(i);
    endsequence

    grant_connects_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      s_claim |=> s_connected)
      else $error("Granted input not connected");

    busy_stalls_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (state_q[i] == WPR_WAIT_HDR && head_valid[i] &&
       !head_char[i].is_ctrl && busy_q[req_port[i]])
      |-> !pop[i] && !grant[i])
      else $error("Header left while its output busy");

    header_delete_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      grant[i] |-> (pop[i] == HDR_DELETE_IN[req_port[i]]))
      else $error("Header deletion not as configured");

    release_wait_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (state_q[i] == WPR_FORWARD && pop[i] && head_char[i].is_ctrl)
      |=> state_q[i] == WPR_WAIT_HDR && !busy_q[$past(tgt_q[i])])
      else $error("End marker did not release output");

    // A blocked header keeps its credit withheld
    stall_holds_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (state_q[i] == WPR_WAIT_HDR && head_valid[i] &&
       !head_char[i].is_ctrl && busy_q[req_port[i]] &&
       !IN_READY_OUT[i]) |=> !IN_READY_OUT[i])
      else $error("Credit returned while header blocked");

    // Held in reset, the input waits for a leading character
    reset_waits_a: assert property (
      @(posedge CORE_CLK_IN)
      !RESET_N_IN |-> state_q[i] == WPR_WAIT_HDR)
      else $error("Input not waiting during reset");
  end

  // Checks per output
  for (genvar k = 0; k < NP; k++) begin : g_chk_out
    busy_until_end_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      $fell(busy_q[k]) |-> out_valid_q[k] && out_char_q[k].is_ctrl)
      else $error("Output freed without end marker");

    single_owner_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      busy_q[k] |-> state_q[owner_q[k]] == WPR_FORWARD &&
                    tgt_q[owner_q[k]] == PW'(k))
      else $error("Busy output without a matching owner");

    end_forwarded_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      load_end[k] |=> out_valid_q[k] && out_char_q[k].is_ctrl)
      else $error("End marker not forwarded");

    // Downstream refusal: the offered character stays put
    sequence s_offer_refused;
      out_valid_q[k] && !OUT_READY_IN[k];
    endsequence
    sequence s_offer_held;
      out_valid_q[k] && $stable(out_char_q[k]);
    endsequence

    offer_held_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      s_offer_refused |=> s_offer_held)
      else $error("Refused output character not held");

    // An unallocated, empty output stays silent
    idle_quiet_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (!busy_q[k] && !out_valid_q[k]) |=> !out_valid_q[k])
      else $error("Character on an unallocated output");

    // A free output asked for by a header is claimed at once
    claim_at_once_a: assert property (
      @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
      (hdr_wants[k] && !busy_q[k]) |=> busy_q[k])
      else $error("Free output not claimed by waiting header");

    // Held in reset, every output is free and silent
    reset_free_a: assert property (
      @(posedge CORE_CLK_IN)
      !RESET_N_IN |-> !busy_q[k] && !out_valid_q[k])
      else $error("Output not free during reset");
  end

endmodule // wpr_router

// [wpr_node_sink.sv]
// Downstream node model that takes characters from every router output
`timescale 1ns/1ps

module wpr_node_sink (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [3:0]           valid_in,
  input  wpr_pkg::wpr_char_t        char_in [4],
  input  wire logic [3:0]           stall_in,
  output logic [3:0]                ready_out
);
  import wpr_pkg::*;

  logic [7:0] lead_q  [4][$];
  logic [9:0] got_q   [4][$];
  logic [3:0] first_q;

  // Credit only while the node has room; stall stands for a full buffer
  assign ready_out = rst_n_in ? ~stall_in : 4'h0;

  // Leading character names the task, so it is kept apart from the rest
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_q <= 4'hf;
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (valid_in[p] && ready_out[p]) begin
          if (first_q[p] && !char_in[p].is_ctrl)
            lead_q[p].push_back(char_in[p].data);
          else
            got_q[p].push_back(char_in[p]);
          first_q[p] <= char_in[p].is_ctrl;
        end
      end
    end
  end
endmodule // wpr_node_sink

// [wpr_router_tb.sv]
// Self-checking testbench for the wormhole packet router
`timescale 1ns/1ps
`include "wpr_defines.svh"

module wpr_router_tb;
  import wpr_pkg::*;

  localparam logic [9:0] EOP = 10'h200;
  localparam logic [9:0] EEP = 10'h300;

  logic       clk;
  logic       rst_n;
  logic [3:0] in_valid;
  wpr_char_t  in_char [4];
  logic [3:0] in_ready;
  logic [3:0] out_valid;
  wpr_char_t  out_char [4];
  logic [3:0] out_ready;
  logic [3:0] busy;
  logic [3:0] stall;
  logic [3:0] hdr_delete;
  int         num_errors;
  int         n_checks;

  // Deletion only on output 1, so other ports keep their header
  wpr_router dut_u (
    .CORE_CLK_IN   (clk),
    .RESET_N_IN    (rst_n),
    .IN_VALID_IN   (in_valid),
    .IN_CHAR_IN    (in_char),
    .IN_READY_OUT  (in_ready),
    .OUT_VALID_OUT (out_valid),
    .OUT_CHAR_OUT  (out_char),
    .OUT_READY_IN  (out_ready),
    .HDR_DELETE_IN (hdr_delete),
    .PORT_BUSY_OUT (busy)
  );

  wpr_node_sink sink_u (
    .clk_in    (clk),
    .rst_n_in  (rst_n),
    .valid_in  (out_valid),
    .char_in   (out_char),
    .stall_in  (stall),
    .ready_out (out_ready)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A bound that runs out is a mismatch and ends the run
  task automatic give_up(input int n, input int lim);
    num_errors++;
    $display("MISMATCH t=%0t timeout got=%h exp=%h", $time, n, lim);
    summarize();
  endtask

  // Offer each character until taken; ready is stable at the falling edge
  task automatic send(input int i, input logic [9:0] c[$]);
    int n;
    foreach (c[k]) begin
      @(negedge clk);
      in_valid[i] = 1'b1;
      in_char[i]  = c[k];
      n = 0;
      while (in_ready[i] !== 1'b1) begin
        @(negedge clk);
        n++;
        if (n > 300) begin
          give_up(n, 300);
        end
      end
    end
    @(negedge clk);
    in_valid[i] = 1'b0;
  endtask

  // Wait for a whole packet at the node, then compare it
  task automatic exp_pkt(input int p, input logic [7:0] ld,
                         input logic [9:0] b[$]);
    int n;
    n = 0;
    while (sink_u.got_q[p].size() < b.size()) begin
      @(negedge clk);
      n++;
      if (n > 500) begin
        give_up(n, 500);
      end
    end
    chk({2'b00, sink_u.lead_q[p].pop_front()}, {2'b00, ld});
    foreach (b[k])
      chk(sink_u.got_q[p].pop_front(), b[k]);
  endtask

  task automatic sc_reset();
    chk({6'h00, in_ready}, 10'h00f);
    chk({6'h00, busy | out_valid}, 10'h000);
  endtask

  task automatic sc_basic();
    send(0, '{10'h002, 10'h0aa, 10'h0bb, EOP});
    exp_pkt(2, 8'h02, '{10'h0aa, 10'h0bb, EOP});
    repeat (2) @(negedge clk);
    chk({6'h00, busy}, 10'h000);
  endtask

  task automatic sc_delete();
    send(2, '{10'h001, 10'h005, 10'h0cc, EOP,
              10'h001, 10'h033, EOP});
    exp_pkt(1, 8'h05, '{10'h0cc, EOP});
    exp_pkt(1, 8'h33, '{EOP});
  endtask

  // A marker with no header in front is dropped; identifier 0 is port 0
  task automatic sc_stray();
    send(3, '{EEP, 10'h000, 10'h044, EOP});
    exp_pkt(0, 8'h00, '{10'h044, EOP});
  endtask

  // Second packet to a stalled busy output must back up to its sender
  task automatic sc_contend();
    @(negedge clk);
    stall = 4'h8;
    send(0, '{10'h003, 10'h010, 10'h011, EEP});
    fork
      send(1, '{10'h007, 10'h020, 10'h021, 10'h022,
                10'h023, 10'h024, EOP});
    join_none
    repeat (12) @(negedge clk);
    chk({6'h00, in_ready[1], busy[3], out_valid[3], 1'b0},
        10'h006);
    stall = 4'h0;
    exp_pkt(3, 8'h03, '{10'h010, 10'h011, EEP});
    exp_pkt(3, 8'h07, '{10'h020, 10'h021, 10'h022,
                       10'h023, 10'h024, EOP});
    wait fork;
  endtask

  // Reset in mid-packet frees the claimed output and empties the buffers
  task automatic sc_midreset();
    stall = 4'h4;
    send(0, '{10'h002, 10'h055});
    chk({6'h00, busy}, 10'h004);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({2'b00, in_ready, busy}, 10'h0f0);
    chk({6'h00, out_valid}, 10'h000);
    stall = 4'h0;
    rst_n = 1'b1;
    send(1, '{10'h006, 10'h066, EOP});
    exp_pkt(2, 8'h06, '{10'h066, EOP});
  endtask

  // Main sequence
  initial begin
    rst_n      = 1'b0;
    in_valid   = 4'h0;
    stall      = 4'h0;
    hdr_delete = 4'h2;
    num_errors = 0;
    n_checks   = 0;
    foreach (in_char[k])
      in_char[k] = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    sc_reset();
    rst_n = 1'b1;
    sc_basic();
    sc_delete();
    sc_stray();
    sc_contend();
    sc_midreset();
    summarize();
  end
endmodule // wpr_router_tb
